// ===== hw/sar_adc_control.sv
// control logic for a 10-bit successive approximation converter with four inputs
// assumes a byte-wide cpu port, a comparator that settles within one step,
// and a trigger input synchronous to clk
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - ten bit result, one of four channels
// - hardware start on chosen trigger edge
// - software start via mode register bits
// - hardware mode halts after each conversion
// - software mode converts back to back
// - resolve from top bit, then copy out
// - result sixteen bits, low six zero
// - high byte top eight, low byte two
// - reset clears the result register
// - hold sampled channel until conversion ends
// - mode register takes bit and byte writes
// - reset clears mode register to zero
// - mode field order enable source time edge
// - enable bit zero stops, one runs
// - source zero converts continuously while enabled
// - hardware source waits for trigger edge
// - time code zero gives 140 periods
// - edge code none fall rise both
// - channel register picks input, two bits
module sar_adc_control (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // cpu register port
    input  wire logic [15:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regBitWrite,
    input  wire logic [2:0]  regBitIndex,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        regRead,
    input  wire logic        regWordRead,
    output logic      [15:0] regReadData,
    // analog front end
    input  wire logic        comparatorHigh,
    output logic      [1:0]  analogChannel,
    output logic             sampleActive,
    output logic      [9:0]  trialCode,
    // trigger and interrupt
    input  wire logic        hw_trigger_input,
    output logic             conversion_done_irq
);
    typedef enum logic [1:0] {IDLE, WAIT_TRIGGER, SAMPLE, CONVERT} state_t;

    state_t      state_q;
    logic [7:0]  converter_mode_reg_q;
    logic [7:0]  channel_select_reg_q;
    logic [15:0] conversion_result_reg_q;
    logic [7:0]  timer_q;
    logic [3:0]  bitCount_q;
    logic [1:0]  heldChannel_q;
    logic        sampling_q;
    logic [9:0]  trial_q;
    logic        done_q;
    logic [15:0] readData_q;

    logic        conversion_enable;
    logic        start_source_select;
    logic [2:0]  convTime;
    logic [1:0]  edgeSel;
    logic        trigFire;
    logic        modeWrite;
    logic        channelWrite;
    logic        finishing;
    logic [7:0]  modeNext;

    sar_step_if stepBus ();

    assign conversion_enable   = converter_mode_reg_q[sar_adc_pkg::ENABLE_BIT];
    assign start_source_select = converter_mode_reg_q[sar_adc_pkg::SOURCE_BIT];
    assign convTime            = converter_mode_reg_q[sar_adc_pkg::TIME_MSB:sar_adc_pkg::TIME_LSB];
    assign edgeSel             = converter_mode_reg_q[sar_adc_pkg::EDGE_MSB:sar_adc_pkg::EDGE_LSB];

    // byte address decode; bit writes reach the mode register only, the channel register takes byte writes
    assign modeWrite    = (regWrite | regBitWrite) && regAddr == sar_adc_pkg::MODE_ADDR;
    assign channelWrite = regWrite && regAddr == sar_adc_pkg::CHANNEL_ADDR;

    // a single bit write modifies one bit and keeps the rest
    always_comb begin
        modeNext = converter_mode_reg_q;
        if (regBitWrite) begin
            modeNext[regBitIndex] = regWriteData[0];
        end else begin
            modeNext = regWriteData;
        end
        modeNext = modeNext & sar_adc_pkg::MODE_WRITE_MASK;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_mode_reg_q <= sar_adc_pkg::MODE_RESET;
        end else if (modeWrite) begin
            converter_mode_reg_q <= modeNext;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_select_reg_q <= sar_adc_pkg::CHANNEL_RESET;
        end else if (channelWrite) begin
            channel_select_reg_q <= regWriteData & sar_adc_pkg::CHANNEL_MASK;
        end
    end

    trigger_edge_detect edgeDetect (
        .clk     (clk),
        .reset_n (reset_n),
        .trigIn  (hw_trigger_input),
        .edgeSel (edgeSel),
        .fire    (trigFire)
    );

    approximation_register sar (
        .clk     (clk),
        .reset_n (reset_n),
        .port    (stepBus)
    );

    // a mode or channel write in the last step wins: no result, no pulse
    assign finishing = state_q == CONVERT && timer_q == 8'h01 && stepBus.lastBit
                       && bitCount_q == 4'h9 && !modeWrite && !channelWrite;

    // only time code zero is legal at this clock; other codes run the same length
    // rather than produce out-of-spec short conversions
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= IDLE;
            timer_q    <= 8'h00;
            bitCount_q <= 4'h0;
        end else if (!conversion_enable) begin
            state_q    <= IDLE;
            timer_q    <= 8'h00;
            bitCount_q <= 4'h0;
        end else if (modeWrite || channelWrite) begin
            // rewriting control aborts the conversion and starts over
            // the written source picks the restart path, so a source switch never converts untriggered
            state_q    <= (modeWrite ? modeNext[sar_adc_pkg::SOURCE_BIT] : start_source_select)
                          ? WAIT_TRIGGER : SAMPLE;
            timer_q    <= sar_adc_pkg::SAMPLE_COUNT;
            bitCount_q <= 4'h0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    state_q <= start_source_select ? WAIT_TRIGGER : SAMPLE;
                    timer_q <= sar_adc_pkg::SAMPLE_COUNT;
                end
                WAIT_TRIGGER: begin
                    if (trigFire) begin
                        state_q <= SAMPLE;
                        timer_q <= sar_adc_pkg::SAMPLE_COUNT;
                    end
                end
                SAMPLE: begin
                    if (timer_q == 8'h01) begin
                        state_q    <= CONVERT;
                        timer_q    <= sar_adc_pkg::STEP_COUNT;
                        bitCount_q <= 4'h0;
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                CONVERT: begin
                    if (timer_q == 8'h01) begin
                        bitCount_q <= bitCount_q + 4'h1;
                        timer_q    <= sar_adc_pkg::STEP_COUNT;
                        if (stepBus.lastBit) begin
                            // hardware start halts, software start repeats
                            state_q <= start_source_select ? WAIT_TRIGGER : SAMPLE;
                            timer_q <= sar_adc_pkg::SAMPLE_COUNT;
                        end
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // clear throughout sampling, one decision at the end of each step
    assign stepBus.clear    = state_q == SAMPLE;
    assign stepBus.step     = state_q == CONVERT && timer_q == 8'h01;
    assign stepBus.decision = comparatorHigh;

    // channel is latched when sampling begins and held through the conversion;
    // a restart re-enters the first sample cycle or the trigger wait, so a channel write takes the new input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            heldChannel_q <= 2'h0;
        end else if (state_q == IDLE || state_q == WAIT_TRIGGER
                     || (state_q == SAMPLE && timer_q == sar_adc_pkg::SAMPLE_COUNT)) begin
            heldChannel_q <= channel_select_reg_q[1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sampling_q <= 1'b0;
            trial_q    <= 10'h000;
        end else begin
            sampling_q <= state_q == SAMPLE && !(timer_q == 8'h01);
            trial_q    <= stepBus.value;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_result_reg_q <= sar_adc_pkg::RESULT_RESET;
        end else if (finishing) begin
            // final decision folded in, left-justified with zero padding
            conversion_result_reg_q <= {stepBus.value[9:1], comparatorHigh,
                                        {sar_adc_pkg::PAD_BITS{1'b0}}};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= finishing;
        end
    end

    // word read returns the whole result; byte reads sit in the low byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= 16'h0000;
        end else if (regRead) begin
            if (regWordRead && regAddr == sar_adc_pkg::RESULT_LO_ADDR) begin
                readData_q <= conversion_result_reg_q;
            end else if (regAddr == sar_adc_pkg::RESULT_LO_ADDR) begin
                readData_q <= {8'h00, conversion_result_reg_q[7:0]};
            end else if (regAddr == sar_adc_pkg::RESULT_HI_ADDR) begin
                readData_q <= {8'h00, conversion_result_reg_q[15:8]};
            end else if (regAddr == sar_adc_pkg::MODE_ADDR) begin
                readData_q <= {8'h00, converter_mode_reg_q};
            end else if (regAddr == sar_adc_pkg::CHANNEL_ADDR) begin
                readData_q <= {8'h00, channel_select_reg_q};
            end else begin
                readData_q <= 16'h0000;
            end
        end
    end

    assign regReadData         = readData_q;
    assign analogChannel       = heldChannel_q;
    assign sampleActive        = sampling_q;
    assign trialCode           = trial_q;
    assign conversion_done_irq = done_q;
endmodule
`default_nettype wire

// ===== inc/sar_adc_pkg.sv
// package for the sar converter control block: register map, fields, timing
// assumes a 200 MHz clock and byte-wide cpu register access
package sar_adc_pkg;
    // register addresses
    localparam logic [15:0] RESULT_LO_ADDR  = 16'hff16;
    localparam logic [15:0] RESULT_HI_ADDR  = 16'hff17;
    localparam logic [15:0] MODE_ADDR       = 16'hff80;
    localparam logic [15:0] CHANNEL_ADDR    = 16'hff81;
    // reset values
    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [7:0]  MODE_RESET      = 8'h00;
    localparam logic [7:0]  CHANNEL_RESET   = 8'h00;
    // mode register fields and write masks
    localparam int          ENABLE_BIT      = 7;
    localparam int          SOURCE_BIT      = 6;
    localparam int          TIME_MSB        = 5;
    localparam int          TIME_LSB        = 3;
    localparam int          EDGE_MSB        = 2;
    localparam int          EDGE_LSB        = 1;
    localparam logic [7:0]  MODE_WRITE_MASK = 8'hfe;
    localparam logic [7:0]  CHANNEL_MASK    = 8'h03;
    // converter geometry
    localparam int          RESULT_BITS     = 10;
    localparam int          PAD_BITS        = 6;
    // trigger edge codes
    localparam logic [1:0]  EDGE_NONE       = 2'h0;
    localparam logic [1:0]  EDGE_FALL       = 2'h1;
    localparam logic [1:0]  EDGE_RISE       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;
    // conversion time: 144 main clock periods nominal; steps round down to 12, so 20 sampling plus 120 converting run 140
    localparam int          CONV_PERIODS    = 144;
    localparam int          SAMPLE_PERIODS  = 20;
    localparam int          STEP_PERIODS    = (CONV_PERIODS - SAMPLE_PERIODS) / RESULT_BITS;
    localparam logic [7:0]  SAMPLE_COUNT    = 8'(SAMPLE_PERIODS);
    localparam logic [7:0]  STEP_COUNT      = 8'(STEP_PERIODS);
endpackage

// ===== inc/sar_step_if.sv
// interface carrying the approximation step handshake between sequencer and register
// assumes one clock domain shared by both modules
`timescale 1ns/1ps
`default_nettype none
interface sar_step_if;
    logic       clear;
    logic       step;
    logic       decision;
    logic [9:0] value;
    logic       lastBit;
    modport seq (output clear, output step, output decision, input value, input lastBit);
    modport sar (input clear, input step, input decision, output value, output lastBit);
endinterface
`default_nettype wire

// ===== hw/approximation_register.sv
// successive approximation register, resolved from the top bit downward
// assumes the sequencer clears it before the first step of each conversion
`timescale 1ns/1ps
`default_nettype none
module approximation_register (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // step control
    sar_step_if.sar   port
);
    logic [9:0] trial_q;
    logic [9:0] value_q;

    assign port.value   = value_q;
    assign port.lastBit = trial_q[0];

    // keep the decided bit, then try the next lower one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trial_q <= 10'h200;
            value_q <= 10'h000;
        end else if (port.clear) begin
            trial_q <= 10'h200;
            value_q <= 10'h200;
        end else if (port.step) begin
            trial_q <= trial_q >> 1;
            value_q <= (port.decision ? value_q : (value_q & ~trial_q)) | (trial_q >> 1);
        end
    end
endmodule
`default_nettype wire

// ===== hw/trigger_edge_detect.sv
// edge qualifier for the hardware start input
// assumes the trigger input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module trigger_edge_detect (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // trigger
    input  wire logic       trigIn,
    input  wire logic [1:0] edgeSel,
    output logic            fire
);
    logic prev_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) prev_q <= 1'b0;
        else          prev_q <= trigIn;
    end

    always_comb begin
        unique case (edgeSel)
            sar_adc_pkg::EDGE_NONE: fire = 1'b0;
            sar_adc_pkg::EDGE_FALL: fire = prev_q & ~trigIn;
            sar_adc_pkg::EDGE_RISE: fire = ~prev_q & trigIn;
            sar_adc_pkg::EDGE_BOTH: fire = prev_q ^ trigIn;
        endcase
    end
endmodule
`default_nettype wire

// ===== verification/sar_adc_props.sv
// checker for the converter control block: pulse timing, sample length, read-back
// assumes it is bound to sar_adc_control and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module sar_adc_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // cpu register port
    input wire logic [15:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regBitWrite,
    input wire logic [2:0]  regBitIndex,
    input wire logic [7:0]  regWriteData,
    input wire logic        regRead,
    input wire logic        regWordRead,
    input wire logic [15:0] regReadData,
    // analog front end
    input wire logic        comparatorHigh,
    input wire logic [1:0]  analogChannel,
    input wire logic        sampleActive,
    input wire logic [9:0]  trialCode,
    // trigger and interrupt
    input wire logic        hw_trigger_input,
    input wire logic        conversion_done_irq
);
    logic [7:0] irqAge_q;
    logic [4:0] sRun_q;
    logic [2:0] wrAge_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) irqAge_q <= 8'h00;
        else if (conversion_done_irq) irqAge_q <= 8'h00;
        else if (irqAge_q != 8'hff) irqAge_q <= irqAge_q + 8'h01;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) sRun_q <= 5'h00;
        else sRun_q <= sampleActive ? sRun_q + 5'h01 : 5'h00;
    end
    // writes abort or restart a conversion, so the trial and channel checks skip their wake
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) wrAge_q <= 3'h0;
        else if (regWrite || regBitWrite) wrAge_q <= 3'h0;
        else if (wrAge_q != 3'h7) wrAge_q <= wrAge_q + 3'h1;
    end
    irq_single_a: assert property (conversion_done_irq |=> !conversion_done_irq)
        else $error("done pulse longer than one cycle");
    irq_spacing_a: assert property (conversion_done_irq |-> irqAge_q >= 8'h8b)
        else $error("conversions closer than 140 cycles");
    sample_len_a: assert property (sampleActive |-> sRun_q < 5'h14)
        else $error("sample phase longer than 20 cycles");
    trial_msb_a: assert property ($fell(sampleActive) && wrAge_q == 3'h7 |-> ##[0:3] trialCode == 10'h200)
        else $error("first trial is not the top bit");
    chan_hold_a: assert property (trialCode != 10'h000 && wrAge_q == 3'h7 |-> $stable(analogChannel))
        else $error("channel moved during conversion");
    mode_read_a: assert property (regRead && regAddr == sar_adc_pkg::MODE_ADDR
        |=> regReadData[15:8] == 8'h00 && !regReadData[0])
        else $error("mode read shows reserved bits");
    pad_zero_a: assert property (regRead && regWordRead && regAddr == sar_adc_pkg::RESULT_LO_ADDR
        |=> regReadData[5:0] == 6'h00)
        else $error("result padding not zero");
    chan_bits_a: assert property (regRead && regAddr == sar_adc_pkg::CHANNEL_ADDR
        |=> regReadData[15:2] == 14'h0000)
        else $error("channel read shows upper bits");
    cover property (conversion_done_irq);
    cover property ($fell(sampleActive));
    cover property (regBitWrite);
endmodule
bind sar_adc_control sar_adc_props props (.clk, .reset_n, .regAddr, .regWrite, .regBitWrite, .regBitIndex,
    .regWriteData, .regRead, .regWordRead, .regReadData, .comparatorHigh, .analogChannel, .sampleActive,
    .trialCode, .hw_trigger_input, .conversion_done_irq);
`default_nettype wire

// ===== verification/analog_front_model.sv
// sample/hold and comparator model: one fixed level per input channel
// assumes trial code and held channel come straight from the converter
`timescale 1ns/1ps
`default_nettype none
module analog_front_model #(
    parameter logic [39:0] LEVELS = 40'h0
) (
    // from the converter
    input  wire logic [1:0] analogChannel,
    input  wire logic       sampleActive,
    input  wire logic [9:0] trialCode,
    // to the converter
    output logic            comparatorHigh
);
    logic [9:0] held = 10'h000;
    // held value ignores channel moves outside sampling, as the real hold does
    always @* begin
        if (sampleActive) held = LEVELS[analogChannel*10 +: 10];
    end
    assign comparatorHigh = held >= trialCode; // levels static, shared pins left quiet
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the converter control block
// assumes the comparator model and the bound checker are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [39:0] LEVELS = {10'h000, 10'h3ff, 10'h15a, 10'h2a5};
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regBitWrite = 1'b0;
    logic [2:0]  regBitIndex = 3'h0;
    logic [7:0]  regWriteData = 8'h00;
    logic        regRead = 1'b0;
    logic        regWordRead = 1'b0;
    logic [15:0] regReadData;
    logic        comparatorHigh;
    logic [1:0]  analogChannel;
    logic        sampleActive;
    logic [9:0]  trialCode;
    logic        trig = 1'b0;
    logic        irq;
    logic [15:0] rd;
    logic [9:0]  lv;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc;
    initial forever #2.5 clk = ~clk;
    sar_adc_control uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
        .regBitWrite(regBitWrite), .regBitIndex(regBitIndex), .regWriteData(regWriteData), .regRead(regRead),
        .regWordRead(regWordRead), .regReadData(regReadData), .comparatorHigh(comparatorHigh),
        .analogChannel(analogChannel), .sampleActive(sampleActive), .trialCode(trialCode),
        .hw_trigger_input(trig), .conversion_done_irq(irq));
    analog_front_model #(.LEVELS(LEVELS)) front (.analogChannel(analogChannel), .sampleActive(sampleActive),
        .trialCode(trialCode), .comparatorHigh(comparatorHigh));
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
    endtask
    task automatic bitwr(input logic [2:0] idx, input logic v);
        @(posedge clk);
        #1;
        regAddr = sar_adc_pkg::MODE_ADDR;
        regBitIndex = idx;
        regWriteData = {7'h00, v};
        regBitWrite = 1'b1;
        @(posedge clk);
        #1;
        regBitWrite = 1'b0;
    endtask
    task automatic rdreg(input logic [15:0] a, input logic word, output logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWordRead = word;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regWordRead = 1'b0;
        d = regReadData;
    endtask
    // cyc is the cycle count until the pulse, or -1 if the window closed
    task automatic wait_irq(input int bound, output int n);
        n = -1;
        for (int i = 0; i < bound && n < 0; i++) begin
            @(posedge clk);
            #1;
            if (irq === 1'b1) n = i;
        end
    endtask
    task automatic need_irq();
        wait_irq(400, cyc);
        if (cyc < 0) begin
            num_errors++;
            $display("MISMATCH irq expected 1 seen 0");
            wrap_up();
        end
    endtask
    task automatic reset_vals();
        rdreg(sar_adc_pkg::MODE_ADDR, 1'b0, rd);
        check("mode", 16'h0000, rd);
        rdreg(sar_adc_pkg::CHANNEL_ADDR, 1'b0, rd);
        check("channel", 16'h0000, rd);
        rdreg(sar_adc_pkg::RESULT_LO_ADDR, 1'b1, rd);
        check("result", 16'h0000, rd);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        reset_vals();
        wr(sar_adc_pkg::MODE_ADDR, 8'h3f);
        rdreg(sar_adc_pkg::MODE_ADDR, 1'b0, rd);
        check("mode", 16'h003e, rd);
        wr(sar_adc_pkg::MODE_ADDR, 8'h00);
        bitwr(3'h5, 1'b1);
        bitwr(3'h0, 1'b1);
        rdreg(sar_adc_pkg::MODE_ADDR, 1'b0, rd);
        check("mode", 16'h0020, rd);
        wr(sar_adc_pkg::MODE_ADDR, 8'h00);
        wr(sar_adc_pkg::CHANNEL_ADDR, 8'hff);
        rdreg(sar_adc_pkg::CHANNEL_ADDR, 1'b0, rd);
        check("channel", 16'h0003, rd);
        rdreg(16'hff82, 1'b0, rd);
        check("unmapped", 16'h0000, rd);
        wr(sar_adc_pkg::RESULT_HI_ADDR, 8'hff);
        rdreg(sar_adc_pkg::RESULT_LO_ADDR, 1'b1, rd);
        check("result", 16'h0000, rd);
        for (int ch = 0; ch < 4; ch++) begin
            lv = LEVELS[ch*10 +: 10];
            wr(sar_adc_pkg::CHANNEL_ADDR, 8'(ch));
            wr(sar_adc_pkg::MODE_ADDR, 8'h80);
            need_irq();
            check("channel", 16'(ch), {14'h0000, analogChannel});
            wait_irq(400, cyc);
            check("gap", 16'h0001, {15'h0000, cyc >= 139 && cyc <= 150});
            rdreg(sar_adc_pkg::RESULT_LO_ADDR, 1'b1, rd);
            check("result", {lv, 6'h00}, rd);
            rdreg(sar_adc_pkg::RESULT_HI_ADDR, 1'b0, rd);
            check("high", {8'h00, lv[9:2]}, rd);
            rdreg(sar_adc_pkg::RESULT_LO_ADDR, 1'b0, rd);
            check("low", {8'h00, lv[1:0], 6'h00}, rd);
            wr(sar_adc_pkg::MODE_ADDR, 8'h00);
            wait_irq(300, cyc);
            check("stopped", 16'h0000, {15'h0000, cyc >= 0});
        end
        for (int e = 0; e < 4; e++) begin
            wr(sar_adc_pkg::MODE_ADDR, 8'hc0 | 8'(e << 1));
            wait_irq(200, cyc);
            check("armed", 16'h0000, {15'h0000, cyc >= 0});
            trig = 1'b1;
            wait_irq(200, cyc);
            check("rise", {15'h0000, e[1]}, {15'h0000, cyc >= 0});
            trig = 1'b0;
            wait_irq(200, cyc);
            check("fall", {15'h0000, e[0]}, {15'h0000, cyc >= 0});
        end
        // a channel write mid-conversion must restart with a fresh sample of the new input
        wr(sar_adc_pkg::CHANNEL_ADDR, 8'h01);
        wr(sar_adc_pkg::MODE_ADDR, 8'h80);
        repeat (3) @(posedge clk);
        #1;
        check("started", 16'h0001, {15'h0000, sampleActive});
        repeat (77) @(posedge clk);
        wr(sar_adc_pkg::CHANNEL_ADDR, 8'h02);
        wait_irq(130, cyc);
        check("restart", 16'h0000, {15'h0000, cyc >= 0});
        need_irq();
        check("new channel", 16'h0002, {14'h0000, analogChannel});
        rdreg(sar_adc_pkg::RESULT_LO_ADDR, 1'b1, rd);
        check("restart result", {LEVELS[29:20], 6'h00}, rd);
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        reset_vals();
        wrap_up();
    end
endmodule
`default_nettype wire
